// ---- core/uart_msd_defs.svh ----
// register indices, reset values and bus constants for the modem status block
`ifndef UART_MSD_DEFS_SVH
`define UART_MSD_DEFS_SVH

// register indices; byte address is the index times four
`define IDX_W 6
`define IDX_MODEM_STATUS 6'h06
`define IDX_SPECIAL_FN 6'h07
`define IDX_DIV_LOW 6'h08
`define IDX_DIV_HIGH 6'h09
`define IDX_RX_VIEW 6'h15
`define IDX_TX_VIEW 6'h16
`define IDX_IRQ_STATUS 6'h18
`define IDX_IRQ_MASK 6'h19

// word alignment of the bus address
`define ADDR_LSB 2
`define MIN_ADDR_W 8
`define MAX_ADDR_W 32

// reset values
`define BYTE_RESET 8'h00
`define LINES_RESET 4'h0
`define WORD_RESET 32'h00000000

// field edges and zero padding of the read data lanes
`define BYTE_MSB 7
`define LINES_MSB 3
`define BYTE_PAD 24'h000000
`define NIBBLE_PAD 4'h0

// writable bits of the special function register (bits 2 and 3 read zero)
`define SF_WRITE_MASK 8'hf3

`endif

// ---- core/uart_msd_pkg.sv ----
// types shared by the modem status, special function and divisor block
package uart_msd_pkg;

  // one bit per modem line; also the layout of irq status and mask
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_s;

  // modem status: live levels in the upper nibble, change flags below
  typedef struct packed {
    modem_lines_s level;
    modem_lines_s change;
  } modem_status_s;

  // special function register layout, msb first
  typedef struct packed {
    logic tx_view_sel;
    logic rx_view_sel;
    logic ext_mode;
    logic spare_rw;
    logic rsvd_hi;
    logic rsvd_lo;
    logic auto_dsr_dtr;
    logic force_tx;
  } special_fn_s;

  // loopback controls from the modem control logic
  typedef struct packed {
    logic loopback;
    logic aux_one;
    logic aux_two;
  } loop_ctl_s;

  // counter values shown through the two selectable views
  typedef struct packed {
    logic [7:0] rx_fifo_fill_count;
    logic [7:0] line_status_err_count;
    logic [7:0] tx_fifo_fill_count;
    logic [7:0] sample_clock_reg;
  } count_views_s;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ANSWER
  } apb_phase_e;

endpackage

// ---- core/uart_msd.sv ----
// modem status, special function and divisor latch registers on apb
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "uart_msd_defs.svh"

module uart_msd
  import uart_msd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire modem_lines_s modem_in,
  input wire loop_ctl_s loop_ctl,
  input wire count_views_s count_views,
  input wire logic rx_room,
  input wire logic dtr_request,
  output logic tx_hold,
  output logic dtr_out,
  output logic force_tx,
  output logic auto_dsr_dtr,
  output logic ext_mode,
  output logic [15:0] divisor,
  output logic divisor_load,
  output logic irq
);

  // refuse an address bus too narrow for the highest index
  if (ADDR_W < `MIN_ADDR_W) begin : g_addr_check
    $error("uart_msd: ADDR_W too small for register map");
  end

  // refuse an address bus wider than the bus protocol carries
  if (ADDR_W > `MAX_ADDR_W) begin : g_addr_max
    $error("uart_msd: ADDR_W wider than the apb address");
  end

  // whole state of the block
  typedef struct packed {
    // bus answer
    apb_phase_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    // modem line pipeline and change flags
    modem_lines_s sync1;
    modem_lines_s sync2;
    modem_lines_s prev;
    modem_lines_s change;
    // software registers and what follows from them
    special_fn_s special_function_control;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [15:0] divisor;
    logic div_load;
    modem_lines_s irq_status;
    modem_lines_s irq_mask;
    logic irq;
    logic tx_hold;
    logic dtr_out;
  } state_s;

  // present and next state
  state_s s;
  state_s next_s;

  // word index of a bus address
  function automatic logic [`IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[`ADDR_LSB +: `IDX_W];
  endfunction

  // true when the address is word aligned and no upper bits are set
  function automatic logic aligned(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] top;
    top = a >> (`ADDR_LSB + `IDX_W);
    aligned = (a[`ADDR_LSB-1:0] == '0) && (top == '0);
  endfunction

  // change events: any edge for cts, dsr, dcd; rising edge only for ri
  function automatic modem_lines_s events_of(input modem_lines_s cur,
                                             input modem_lines_s old);
    modem_lines_s ev;
    ev = cur ^ old;
    ev.ri = cur.ri & ~old.ri;
    events_of = ev;
  endfunction

  // sticky flags: keep what was not cleared, a new event always wins
  function automatic modem_lines_s sticky_next(input modem_lines_s old,
                                               input modem_lines_s clr,
                                               input modem_lines_s evt);
    sticky_next = (old & ~clr) | evt;
  endfunction

  // four line bits widened to a register byte, upper bits read zero
  function automatic logic [`BYTE_MSB:0] lines_byte(input modem_lines_s v);
    lines_byte = {`NIBBLE_PAD, v};
  endfunction

  // combinational working values
  modem_lines_s cur;
  modem_lines_s ev;
  modem_lines_s reported;
  modem_lines_s w1c;
  modem_status_s msr_view;
  logic access;
  logic done;
  logic [`IDX_W-1:0] idx;
  logic ok;
  logic [7:0] rd_byte;
  logic hit;
  logic wr_en;
  logic rd_en;
  logic hold_req;

  always_comb begin
    // start from the present state; the load strobe lasts one cycle
    next_s = s;
    next_s.div_load = 1'b0;

    // second synchroniser stage, with loopback sources replacing ri and dcd
    cur = s.sync2;
    if (loop_ctl.loopback) begin
      cur.ri = loop_ctl.aux_one;
      cur.dcd = loop_ctl.aux_two;
    end

    // two flops per modem line, then one more for edge detection
    next_s.sync1 = modem_in;
    next_s.sync2 = s.sync1;
    next_s.prev = cur;

    // change events from the synchronised levels
    ev = events_of(cur, s.prev);

    // live levels and sticky flags as software sees them
    msr_view.level = cur;
    msr_view.change = s.change;

    // bus decode
    access = psel & penable;
    done = access & s.pready;
    idx = idx_of(paddr);
    ok = aligned(paddr);

    // read data mux, one byte in the low lane
    hit = 1'b1;
    rd_byte = `BYTE_RESET;
    case (idx)
      `IDX_MODEM_STATUS: begin
        rd_byte = msr_view;
      end
      `IDX_SPECIAL_FN: begin
        rd_byte = s.special_function_control;
      end
      `IDX_DIV_LOW: begin
        rd_byte = s.div_low;
      end
      `IDX_DIV_HIGH: begin
        rd_byte = s.div_high;
      end
      `IDX_RX_VIEW: begin
        if (s.special_function_control.rx_view_sel) begin
          rd_byte = count_views.line_status_err_count;
        end else begin
          rd_byte = count_views.rx_fifo_fill_count;
        end
      end
      `IDX_TX_VIEW: begin
        if (s.special_function_control.tx_view_sel) begin
          rd_byte = count_views.tx_fifo_fill_count;
        end else begin
          rd_byte = count_views.sample_clock_reg;
        end
      end
      `IDX_IRQ_STATUS: begin
        rd_byte = lines_byte(s.irq_status);
      end
      `IDX_IRQ_MASK: begin
        rd_byte = lines_byte(s.irq_mask);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    hit = hit & ok;

    // a transfer completes at the edge that sees pready high
    wr_en = done & pwrite & hit;
    rd_en = done & ~pwrite & hit;

    // flags cleared by this transfer, none unless it completes
    reported = `LINES_RESET;
    w1c = `LINES_RESET;

    // apb slave: answer one cycle into the access phase
    case (s.phase)
      PH_IDLE: begin
        // the first access edge captures the answer
        next_s.pready = 1'b0;
        if (access) begin
          next_s.pready = 1'b1;
          next_s.pslverr = ~hit;
          next_s.phase = PH_ANSWER;
          if (!pwrite && hit) begin
            next_s.prdata = {`BYTE_PAD, rd_byte};
          end else begin
            next_s.prdata = `WORD_RESET;
          end
        end
      end
      PH_ANSWER: begin
        // the completion edge: writes land and reported flags clear
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.phase = PH_IDLE;
        if (wr_en) begin
          case (idx)
            `IDX_SPECIAL_FN: begin
              next_s.special_function_control = pwdata[`BYTE_MSB:0] & `SF_WRITE_MASK;
            end
            `IDX_DIV_LOW: begin
              next_s.div_low = pwdata[`BYTE_MSB:0];
              next_s.div_load = 1'b1;
            end
            `IDX_DIV_HIGH: begin
              next_s.div_high = pwdata[`BYTE_MSB:0];
              next_s.div_load = 1'b1;
            end
            `IDX_IRQ_STATUS: begin
              w1c = pwdata[`LINES_MSB:0];
            end
            `IDX_IRQ_MASK: begin
              next_s.irq_mask = pwdata[`LINES_MSB:0];
            end
            `IDX_MODEM_STATUS, `IDX_RX_VIEW, `IDX_TX_VIEW: begin
              // read-only views drop the write without an error
              next_s.div_load = 1'b0;
            end
            default: begin
              next_s.div_load = 1'b0;
            end
          endcase
        end
        if (rd_en && idx == `IDX_MODEM_STATUS) begin
          // clear only the flags that went out in the read data
          reported = s.prdata[3:0];
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
      end
    endcase

    // sticky change flags: a new event wins over the read clear
    next_s.change = sticky_next(s.change, reported, ev);

    // interrupt status, write one to clear, set wins
    next_s.irq_status = sticky_next(s.irq_status, w1c, ev);
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // divisor presented to the baud generator
    next_s.divisor = {next_s.div_high, next_s.div_low};

    // flow control: with auto_dsr_dtr set, dsr low holds the transmitter unless forced
    hold_req = next_s.special_function_control.auto_dsr_dtr & ~cur.dsr;
    next_s.tx_hold = hold_req & ~next_s.special_function_control.force_tx;
    if (next_s.special_function_control.auto_dsr_dtr) begin
      next_s.dtr_out = rx_room;
    end else begin
      next_s.dtr_out = dtr_request;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // bus answer idle
      s.phase <= PH_IDLE;
      s.pready <= 1'b0;
      s.pslverr <= 1'b0;
      s.prdata <= `WORD_RESET;
      // pipeline starts at the idle low level, so no false edge follows
      s.sync1 <= `LINES_RESET;
      s.sync2 <= `LINES_RESET;
      s.prev <= `LINES_RESET;
      s.change <= `LINES_RESET;
      // software registers and their outputs
      s.special_function_control <= `BYTE_RESET;
      s.div_low <= `BYTE_RESET;
      s.div_high <= `BYTE_RESET;
      s.divisor <= {`BYTE_RESET, `BYTE_RESET};
      s.div_load <= 1'b0;
      s.irq_status <= `LINES_RESET;
      s.irq_mask <= `LINES_RESET;
      s.irq <= 1'b0;
      s.tx_hold <= 1'b0;
      s.dtr_out <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // bus answer straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

  // flow control and mode outputs
  assign tx_hold = s.tx_hold;
  assign dtr_out = s.dtr_out;
  assign force_tx = s.special_function_control.force_tx;
  assign auto_dsr_dtr = s.special_function_control.auto_dsr_dtr;
  assign ext_mode = s.special_function_control.ext_mode;

  // baud generator divisor and its load strobe
  assign divisor = s.divisor;
  assign divisor_load = s.div_load;

  // level interrupt
  assign irq = s.irq;

endmodule

// ---- test/uart_msd_asserts.sv ----
// checker for the bus handshake and control outputs of the modem status block
`timescale 1ns/1ns
module uart_msd_asserts
  import uart_msd_pkg::*;
#(parameter int ADDR_W = 8) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_room,
  input wire logic tx_hold,
  input wire logic dtr_out,
  input wire logic force_tx,
  input wire logic auto_dsr_dtr,
  input wire logic [15:0] divisor,
  input wire logic divisor_load
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // handshake: answer exactly one cycle into the access phase
  rdy_timing_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  // divisor only moves on a completed write to one of its bytes
  div_load_a: assert property ($changed(divisor) |-> divisor_load)
    else $error("divisor moved silently");
  div_src_a: assert property (divisor_load |->
    $past(pready && pwrite && paddr[7:2] inside {6'h08, 6'h09})) else $error("stray load");
  force_wr_a: assert property ($changed(force_tx) |->
    $past(pready && pwrite && paddr[7:2] == 6'h07) && force_tx == $past(pwdata[0]))
    else $error("force bit stray");
  force_hold_a: assert property (force_tx && $past(force_tx) |-> !tx_hold)
    else $error("hold despite force");
  dtr_auto_a: assert property (auto_dsr_dtr && $past(auto_dsr_dtr) |->
    dtr_out == $past(rx_room)) else $error("dtr not from rx room");
  cover property (divisor_load);
  cover property (pslverr);
  cover property (auto_dsr_dtr && tx_hold);
endmodule

// ---- test/modem_model.sv ----
// modem side model: drives the four control lines off the clock edge
`timescale 1ns/1ns
module modem_model
  import uart_msd_pkg::*;
#(parameter int SKEW_NS = 3) (
  input wire logic slow,
  input wire logic [3:0] target,
  output modem_lines_s lines
);
  // lines are asynchronous; a slow modem lands them later
  initial lines = 4'h0;
  always @(target) lines <= #(slow ? 3 * SKEW_NS : SKEW_NS) target;
endmodule

// ---- test/tb.sv ----
// testbench for the modem status, special function and divisor block
`timescale 1ns/1ns
module tb;
  import uart_msd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, rx_room, dtr_request, slow, er;
  logic pready, pslverr, tx_hold, dtr_out, force_tx, auto_dsr_dtr, ext_mode;
  logic divisor_load, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] divisor;
  logic [3:0] target;
  modem_lines_s modem_in;
  loop_ctl_s loop_ctl;
  count_views_s count_views;
  int n_fail, samples_checked;
  modem_model modem_model_inst (.slow, .target, .lines(modem_in));
  uart_msd uart_msd_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .modem_in, .loop_ctl, .count_views, .rx_room,
    .dtr_request, .tx_hold, .dtr_out, .force_tx, .auto_dsr_dtr, .ext_mode, .divisor,
    .divisor_load, .irq);
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      test_done;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic lines_to(input logic [3:0] v);
    target <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic reset_values;
    rdc(8'h18, 32'h0);
    rdc(8'h1c, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h24, 32'h0);
  endtask
  task automatic special_fn;
    apb(1'b1, 8'h1c, 32'hff);
    rdc(8'h1c, 32'hf3);
    chk("force", 1, force_tx);
    chk("ext", 1, ext_mode);
    chk("hold", 0, tx_hold);
    rdc(8'h54, 32'h22);
    rdc(8'h58, 32'h33);
    apb(1'b1, 8'h1c, 32'h02);
    repeat (2) @(negedge pclk);
    chk("hold", 1, tx_hold);
    chk("dtr", 1, dtr_out);
    @(posedge pclk);
    rx_room <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("dtr", 0, dtr_out);
    chk("hold", 1, tx_hold);
    apb(1'b1, 8'h1c, 32'h00);
    rdc(8'h54, 32'h11);
    rdc(8'h58, 32'h44);
    chk("dtr", 0, dtr_out);
    @(posedge pclk);
    {rx_room, dtr_request} <= 2'b11;
    repeat (2) @(negedge pclk);
    chk("dtr", 1, dtr_out);
    chk("hold", 0, tx_hold);
  endtask
  task automatic divisor_bytes;
    apb(1'b1, 8'h20, 32'ha5);
    @(negedge pclk);
    chk("div", 32'h00a5, divisor);
    chk("load", 1, divisor_load);
    apb(1'b1, 8'h24, 32'h3c);
    @(negedge pclk);
    chk("div", 32'h3ca5, divisor);
    rdc(8'h24, 32'h3c);
  endtask
  task automatic modem_changes;
    lines_to(4'hf);
    rdc(8'h18, 32'hff);
    rdc(8'h18, 32'hf0);
    slow <= 1'b1;
    lines_to(4'h0);
    rdc(8'h18, 32'h0b);
  endtask
  task automatic irq_flow;
    apb(1'b1, 8'h60, 32'hf);
    apb(1'b1, 8'h64, 32'h1);
    lines_to(4'h2);
    chk("irq", 0, irq);
    lines_to(4'h3);
    chk("irq", 1, irq);
    apb(1'b1, 8'h60, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq", 0, irq);
  endtask
  task automatic loopback;
    rdc(8'h18, 32'h33);
    loop_ctl <= 3'b111;
    repeat (3) @(posedge pclk);
    rdc(8'h18, 32'hfc);
    loop_ctl <= 3'b000;
  endtask
  task automatic bad_access;
    apb(1'b0, 8'h04, 32'h0);
    chk("slverr", 1, er);
    chk("rdata", 0, rd);
    apb(1'b1, 8'h21, 32'h77);
    chk("slverr", 1, er);
    rdc(8'h20, 32'ha5);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, dtr_request, slow} = 5'h0;
    rx_room = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    target = 4'h0;
    loop_ctl = 3'b000;
    count_views = {8'h11, 8'h22, 8'h33, 8'h44};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    reset_values;
    special_fn;
    divisor_bytes;
    modem_changes;
    irq_flow;
    loopback;
    bad_access;
    test_done;
  end
endmodule
bind uart_msd uart_msd_asserts #(.ADDR_W(ADDR_W)) chk_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_room, .tx_hold,
  .dtr_out, .force_tx, .auto_dsr_dtr, .divisor, .divisor_load);
